// file: shared/tx_sync_regs.svh
// Register offsets, field positions, reset values and frame counts
`ifndef TX_SYNC_REGS_SVH
`define TX_SYNC_REGS_SVH
`define SMR_OFF 8'h00
`define CLKSEL_OFF 8'h04
`define STATUS_OFF 8'h08
`define FCOUNT_OFF 8'h0C
`define SMR_ALIGN_BIT 6
`define SMR_MSYNC_BIT 5
`define SMR_SYNC_SEL_BIT 4
`define SMR_CRC_BIT 1
`define SMR_FBIT_BIT 0
`define SMR_RST 8'h00
`define CLKSEL_CSS_LSB 0
`define CLKSEL_BASE_BIT 2
`define CLKSEL_RST 3'h4
`define CSS_RST 2'h0
`define BASE_RST 1'b1
`define CSS_SERCLK 2'h1
`define CSS_RECOV_A 2'h0
`define CSS_RECOV_B 2'h3
`define CSS_PLL 2'h2
`define FRAME_LAST 8'hC0
`define MF_LAST 4'hB
`endif

// file: shared/tx_sync_pkg.sv
// Types shared by the transmit frame sync direction block
package tx_sync_pkg;
   // Stored fields of the sync mux configuration register
   typedef struct packed {
      logic mframe_align;
      logic msync_opt;
      logic sync_sel;
      logic crc_src;
      logic fbit_src;
   } smr_t;
   // Configuration levels handed to the serial clock domain
   typedef struct packed {
      logic sys_ctrl;
      logic base_rate;
   } link_cfg_t;
   // Who currently starts frames on the link side
   typedef enum logic [2:0] {
      LK_DEV = 3'b001,
      LK_WAIT = 3'b010,
      LK_SYS = 3'b100
   } link_state_t;
endpackage

// file: src/tx_frame_sync_select.sv
// APB-controlled frame and multiframe boundary direction and timing
`timescale 1ns/1ns
`default_nettype none
`include "tx_sync_regs.svh"

// Functional notes
// - R/W select bit, reset 0, picks frame master
// - System control makes both boundary pins inputs
// - Sampled high frame input starts new frame
// - Sampled high multiframe input starts multiframe
// - Serial clock source: 0 drives pins, 1 inputs
// - Other sources: 0 drives pins, 1 inputs
// - Field 01 serial clock; 00/11 recovered clock
// - Base rate: multiframe pin boundary, else clock
module tx_frame_sync_select
   import tx_sync_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_serial_clock,
   input wire logic tx_frame_boundary_in,
   output logic tx_frame_boundary_out,
   output logic tx_frame_boundary_oe,
   input wire logic tx_multiframe_boundary_in,
   output logic tx_multiframe_boundary_out,
   output logic tx_multiframe_boundary_oe,
   output logic frame_start,
   output logic mframe_start,
   output logic [7:0] bit_index,
   output logic mf_pin_is_clock
);

   //---------------------------------------------------------------
   // Register file (pclk domain)
   //---------------------------------------------------------------
   smr_t smr_ff;
   logic [1:0] css_ff;
   logic base_rate_ff;
   logic [15:0] frame_cnt_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic mapped;
   logic wr_en;
   logic css_serclk;
   logic css_recov;
   logic css_pll;
   logic [2:0] sys_lock_sync_ff;
   logic [2:0] ftog_sync_ff;

   assign mapped = (paddr == `SMR_OFF) || (paddr == `CLKSEL_OFF) ||
                   (paddr == `STATUS_OFF) || (paddr == `FCOUNT_OFF);
   // Zero wait states: every access completes on its first access cycle
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = psel & penable & pwrite & mapped;
   assign prdata = prdata_ff;

   // Clock source decode
   assign css_serclk = (css_ff == `CSS_SERCLK);
   assign css_recov = (css_ff == `CSS_RECOV_A) ||
                      (css_ff == `CSS_RECOV_B);
   assign css_pll = (css_ff == `CSS_PLL);

   // Configuration writes; the select bit defaults to chip control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smr_ff <= '0;
         css_ff <= `CSS_RST;
         base_rate_ff <= `BASE_RST;
      end else if (wr_en && paddr == `SMR_OFF) begin
         smr_ff.mframe_align <= pwdata[`SMR_ALIGN_BIT];
         smr_ff.msync_opt <= pwdata[`SMR_MSYNC_BIT];
         smr_ff.sync_sel <= pwdata[`SMR_SYNC_SEL_BIT];
         smr_ff.crc_src <= pwdata[`SMR_CRC_BIT];
         smr_ff.fbit_src <= pwdata[`SMR_FBIT_BIT];
      end else if (wr_en && paddr == `CLKSEL_OFF) begin
         css_ff <= pwdata[`CLKSEL_CSS_LSB +: 2];
         base_rate_ff <= pwdata[`CLKSEL_BASE_BIT];
      end
   end

   // Read data is captured in the setup cycle so it leaves a flop
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
         `SMR_OFF: begin
            nxt_prdata[`SMR_ALIGN_BIT] = smr_ff.mframe_align;
            nxt_prdata[`SMR_MSYNC_BIT] = smr_ff.msync_opt;
            nxt_prdata[`SMR_SYNC_SEL_BIT] = smr_ff.sync_sel;
            nxt_prdata[`SMR_CRC_BIT] = smr_ff.crc_src;
            nxt_prdata[`SMR_FBIT_BIT] = smr_ff.fbit_src;
         end
         `CLKSEL_OFF: begin
            nxt_prdata[`CLKSEL_CSS_LSB +: 2] = css_ff;
            nxt_prdata[`CLKSEL_BASE_BIT] = base_rate_ff;
         end
         `STATUS_OFF: begin
            nxt_prdata[0] = smr_ff.sync_sel;
            nxt_prdata[1] = css_serclk;
            nxt_prdata[2] = css_recov;
            nxt_prdata[3] = css_pll;
            nxt_prdata[4] = sys_lock_sync_ff[2];
         end
         `FCOUNT_OFF: begin
            nxt_prdata[15:0] = frame_cnt_ff;
         end
         default: begin
            nxt_prdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // Frame toggle and lock level from the serial domain, three stages
   logic ftog_ff;
   logic sys_lock_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ftog_sync_ff <= 3'h0;
         sys_lock_sync_ff <= 3'h0;
      end else begin
         ftog_sync_ff <= {ftog_sync_ff[1:0], ftog_ff};
         sys_lock_sync_ff <= {sys_lock_sync_ff[1:0], sys_lock_ff};
      end
   end

   // Frames seen, counted once stages two and three disagree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_cnt_ff <= 16'h0000;
      end else if (ftog_sync_ff[2] != ftog_sync_ff[1]) begin
         frame_cnt_ff <= frame_cnt_ff + 16'h0001;
      end
   end

   //---------------------------------------------------------------
   // Serial clock domain
   //---------------------------------------------------------------
   logic [1:0] trst_ff;
   logic trst_n;
   link_cfg_t cfg_meta_ff;
   link_cfg_t cfg_ff;
   link_cfg_t cfg_src;
   link_state_t state_ff;
   link_state_t nxt_state;
   logic fr_in_ff;
   logic mf_in_ff;
   logic [7:0] bit_cnt_ff;
   logic [3:0] mf_cnt_ff;
   logic wrap;
   logic fr_restart;
   logic mf_restart;
   logic nxt_frame;
   logic nxt_mframe;
   logic frame_ff;
   logic mframe_ff;

   // Reset release is retimed so the counters start cleanly
   always_ff @(posedge tx_serial_clock or negedge presetn) begin
      if (!presetn) begin
         trst_ff <= 2'h0;
      end else begin
         trst_ff <= {trst_ff[0], 1'b1};
      end
   end
   assign trst_n = trst_ff[1];

   // Every clock source gives the same direction per select value
   assign cfg_src.sys_ctrl = smr_ff.sync_sel;
   assign cfg_src.base_rate = base_rate_ff;

   // Quasi-static levels cross through two flops
   always_ff @(posedge tx_serial_clock or negedge trst_n) begin
      if (!trst_n) begin
         cfg_meta_ff <= '0;
         cfg_ff <= '0;
      end else begin
         cfg_meta_ff <= cfg_src;
         cfg_ff <= cfg_meta_ff;
      end
   end

   // Boundary inputs are sampled on the serial clock edge
   always_ff @(posedge tx_serial_clock or negedge trst_n) begin
      if (!trst_n) begin
         fr_in_ff <= 1'b0;
         mf_in_ff <= 1'b0;
      end else begin
         fr_in_ff <= tx_frame_boundary_in;
         mf_in_ff <= tx_multiframe_boundary_in;
      end
   end

   // Under system control nothing is sent until the first boundary
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         LK_DEV: begin
            if (cfg_ff.sys_ctrl) begin
               nxt_state = LK_WAIT;
            end
         end
         LK_WAIT: begin
            if (!cfg_ff.sys_ctrl) begin
               nxt_state = LK_DEV;
            end else if (fr_in_ff) begin
               nxt_state = LK_SYS;
            end
         end
         LK_SYS: begin
            if (!cfg_ff.sys_ctrl) begin
               nxt_state = LK_DEV;
            end
         end
         default: begin
            nxt_state = LK_DEV;
         end
      endcase
   end

   always_ff @(posedge tx_serial_clock or negedge trst_n) begin
      if (!trst_n) begin
         state_ff <= LK_DEV;
      end else begin
         state_ff <= nxt_state;
      end
   end
   assign sys_lock_ff = (state_ff == LK_SYS);

   // Frame and multiframe restarts
   assign wrap = (bit_cnt_ff == `FRAME_LAST) && (state_ff != LK_WAIT);
   assign fr_restart = cfg_ff.sys_ctrl && fr_in_ff;
   assign mf_restart = cfg_ff.sys_ctrl && cfg_ff.base_rate &&
                       mf_in_ff;
   assign nxt_frame = fr_restart || (wrap && !cfg_ff.sys_ctrl) ||
                      (wrap && state_ff == LK_SYS);
   // No superframe marks while the pin serves as a backplane clock
   assign nxt_mframe = mf_restart ||
                       (nxt_frame && !cfg_ff.sys_ctrl &&
                        cfg_ff.base_rate &&
                        mf_cnt_ff == `MF_LAST);

   // Bit position within the 193-bit frame
   always_ff @(posedge tx_serial_clock or negedge trst_n) begin
      if (!trst_n) begin
         bit_cnt_ff <= 8'h00;
      end else if (nxt_frame) begin
         bit_cnt_ff <= 8'h00;
      end else if (state_ff != LK_WAIT) begin
         bit_cnt_ff <= bit_cnt_ff + 8'h01;
      end
   end

   // Frame position within the multiframe
   always_ff @(posedge tx_serial_clock or negedge trst_n) begin
      if (!trst_n) begin
         mf_cnt_ff <= 4'h0;
      end else if (nxt_mframe) begin
         mf_cnt_ff <= 4'h0;
      end else if (nxt_frame) begin
         mf_cnt_ff <= (mf_cnt_ff == `MF_LAST) ? 4'h0 :
                      mf_cnt_ff + 4'h1;
      end
   end

   // One-cycle start strobes, and a toggle per frame for software
   always_ff @(posedge tx_serial_clock or negedge trst_n) begin
      if (!trst_n) begin
         frame_ff <= 1'b0;
         mframe_ff <= 1'b0;
         ftog_ff <= 1'b0;
      end else begin
         frame_ff <= nxt_frame;
         mframe_ff <= nxt_mframe;
         ftog_ff <= ftog_ff ^ nxt_frame;
      end
   end

   // Pin drivers; a pin in use as a clock is never driven
   always_ff @(posedge tx_serial_clock or negedge trst_n) begin
      if (!trst_n) begin
         tx_frame_boundary_out <= 1'b0;
         tx_frame_boundary_oe <= 1'b0;
         tx_multiframe_boundary_out <= 1'b0;
         tx_multiframe_boundary_oe <= 1'b0;
      end else begin
         tx_frame_boundary_oe <= !cfg_ff.sys_ctrl;
         tx_multiframe_boundary_oe <= !cfg_ff.sys_ctrl &&
                                      cfg_ff.base_rate;
         tx_frame_boundary_out <= nxt_frame &&
                                  !cfg_ff.sys_ctrl;
         tx_multiframe_boundary_out <= nxt_mframe &&
                                       !cfg_ff.sys_ctrl &&
                                       cfg_ff.base_rate;
      end
   end

   assign frame_start = frame_ff;
   assign mframe_start = mframe_ff;
   assign bit_index = bit_cnt_ff;
   assign mf_pin_is_clock = !cfg_ff.base_rate;

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   a_sel_reset_zero: assert property (@(posedge pclk)
      $rose(presetn) |-> smr_ff.sync_sel == 1'b0)
      else $error("select bit not zero after reset");
   a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `SMR_OFF |=>
      smr_ff.sync_sel == $past(pwdata[`SMR_SYNC_SEL_BIT]))
      else $error("select bit write lost");
   a_css_decode: assert property (@(posedge pclk) disable iff (!presetn)
      css_ff == 2'h3 |-> css_recov && !css_serclk)
      else $error("clock source decode wrong");
   a_pins_inputs: assert property (@(posedge tx_serial_clock)
      disable iff (!trst_n)
      cfg_ff.sys_ctrl |=> !tx_frame_boundary_oe &&
      !tx_multiframe_boundary_oe)
      else $error("boundary pin driven under system control");
   a_pins_outputs: assert property (@(posedge tx_serial_clock)
      disable iff (!trst_n)
      !cfg_ff.sys_ctrl && cfg_ff.base_rate |=>
      tx_frame_boundary_oe && tx_multiframe_boundary_oe)
      else $error("boundary pins not driven under chip control");
   a_frame_restart: assert property (@(posedge tx_serial_clock)
      disable iff (!trst_n)
      cfg_ff.sys_ctrl && fr_in_ff |=> bit_cnt_ff == 8'h00 && frame_ff)
      else $error("frame input did not restart frame");
   a_mframe_restart: assert property (@(posedge tx_serial_clock)
      disable iff (!trst_n)
      mf_restart |=> mf_cnt_ff == 4'h0 && mframe_ff)
      else $error("multiframe input did not restart multiframe");
   a_clock_pin_mode: assert property (@(posedge tx_serial_clock)
      disable iff (!trst_n)
      !cfg_ff.base_rate |=> !tx_multiframe_boundary_oe && !mframe_ff)
      else $error("multiframe pin used while it is a clock");
   a_pulse_width: assert property (@(posedge tx_serial_clock)
      disable iff (!trst_n)
      $rose(tx_frame_boundary_out) |=> !tx_frame_boundary_out)
      else $error("frame boundary output wider than one cycle");
   a_frame_period: assert property (@(posedge tx_serial_clock)
      disable iff (!trst_n)
      !cfg_ff.sys_ctrl && bit_cnt_ff == `FRAME_LAST &&
      state_ff == LK_DEV |=> frame_ff && bit_cnt_ff == 8'h00)
      else $error("chip controlled frame not 193 bits");

endmodule
`default_nettype wire

// file: testbench/sys_side_model.sv
// System-side terminal equipment driving the two boundary inputs
`timescale 1ns/1ns
`default_nettype none
module sys_side_model (
   input wire logic tx_serial_clock,
   input wire logic presetn,
   input wire logic pins_driven,
   input wire logic go,
   input wire logic [7:0] period,
   input wire logic [3:0] mf_len,
   output logic frame_drive,
   output logic mframe_drive
);
   logic [7:0] cnt_ff;
   logic [3:0] fr_ff;
   // One frame pulse per period, a multiframe pulse on every mf_len-th
   // Idles low while stopped or while the device owns the pins
   always_ff @(posedge tx_serial_clock or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 8'h00;
         fr_ff <= 4'h0;
         frame_drive <= 1'b0;
         mframe_drive <= 1'b0;
      end else if (!go || pins_driven) begin
         cnt_ff <= 8'h00;
         frame_drive <= 1'b0;
         mframe_drive <= 1'b0;
      end else if (cnt_ff == period - 8'h01) begin
         cnt_ff <= 8'h00;
         frame_drive <= 1'b1;
         mframe_drive <= (fr_ff == 4'h0);
         fr_ff <= (fr_ff == mf_len - 4'h1) ? 4'h0 : fr_ff + 4'h1;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
         frame_drive <= 1'b0;
         mframe_drive <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: testbench/tx_frame_sync_direction_select_test.sv
// Self-checking bench for the transmit frame sync direction block
`timescale 1ns/1ns
`default_nettype none
`include "tx_sync_regs.svh"
module tx_frame_sync_direction_select_test;
   logic pclk = 0, txc = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, period = 8'h3C;
   logic [31:0] pwdata = 32'h0, d, rnd = 32'h96714195;
   logic [3:0] mf_len = 4'h3;
   logic go = 0, e;
   wire logic [31:0] prdata;
   wire logic [7:0] bit_index;
   wire logic pready, pslverr, fb_out, fb_oe, mf_out, mf_oe, fst, mst, mclk;
   wire logic fdrv, mdrv, fb_pin, mf_pin;
   int fails = 0, n_checks = 0, cyc = 0, fcyc, fgap, nf = 0, nm = 0, fk;
   int mgap, i, m;
   // Pin level from whoever drives it
   assign fb_pin = fb_oe ? fb_out : fdrv;
   assign mf_pin = mf_oe ? mf_out : mdrv;
   tx_frame_sync_select i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_serial_clock(txc), .tx_frame_boundary_in(fb_pin),
      .tx_frame_boundary_out(fb_out), .tx_frame_boundary_oe(fb_oe),
      .tx_multiframe_boundary_in(mf_pin), .tx_multiframe_boundary_out(mf_out),
      .tx_multiframe_boundary_oe(mf_oe), .frame_start(fst),
      .mframe_start(mst), .bit_index(bit_index), .mf_pin_is_clock(mclk));
   sys_side_model i_sys (.tx_serial_clock(txc), .presetn(presetn),
      .pins_driven(fb_oe), .go(go), .period(period), .mf_len(mf_len),
      .frame_drive(fdrv), .mframe_drive(mdrv));
   // Clocks: link clock phase offset from the bus clock on purpose
   initial forever #25 pclk = ~pclk;
   initial forever begin
      #7 txc = 1;
      #8 txc = 0;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected status nibble for a clock source and select value
   function automatic logic [3:0] exp_status(input logic [1:0] c,
         input logic s);
      return {c == 2'h2, c == 2'h0 || c == 2'h3, c == 2'h1, s};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
            exp);
      end
   endtask
   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_frames(input int n);
      int t;
      t = nf + n;
      while (nf < t) @(posedge pclk);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Link monitor: frame spacing, frames per multiframe, pulse shape
   // Sampled on the falling edge, clear of the launching edge
   always @(negedge txc) begin
      fcyc = fcyc + 1;
      if (fst === 1'b1) begin
         fgap = fcyc;
         fcyc = 0;
         nf++;
         fk++;
         if (bit_index !== 8'h00) chk(bit_index, 0, "bit index");
      end
      if (mst === 1'b1) begin
         mgap = fk;
         fk = 0;
         nm++;
      end
      if (fb_oe === 1'b1 && {fb_out, mf_out} !== {fst, mst})
         chk({fb_out, mf_out}, {fst, mst}, "pulse");
   end
   // Hang guard, far above the roughly 1500 bus clock cycles the run needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         $display("wrong value at %0t: timeout", $time);
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, `SMR_OFF, 32'h0);
      chk(d, `SMR_RST, "smr reset");
      apb(1'b0, `CLKSEL_OFF, 32'h0);
      chk(d, `CLKSEL_RST, "clksel reset");
      apb(1'b0, 8'h10, 32'h0);
      chk(d, 32'h0, "unmapped read");
      chk({31'h0, e}, 32'h1, "unmapped error");
      rnd = lfsr(rnd);
      apb(1'b1, `SMR_OFF, rnd);
      apb(1'b0, `SMR_OFF, 32'h0);
      chk(d, rnd & 32'h73, "smr rw");
      apb(1'b1, `SMR_OFF, 32'h0);
      $display("test registers done");
      // Chip control: 193-bit frames, 12 frames per multiframe
      wait_frames(14);
      chk(fgap, `FRAME_LAST + 1, "frame period");
      chk(mgap, `MF_LAST + 1, "multiframe len");
      chk({fb_oe, mf_oe}, 2'b11, "chip drives");
      $display("test chip control done");
      // Every clock source with both select values
      for (i = 0; i < 8; i++) begin
         apb(1'b1, `CLKSEL_OFF, 32'h4 | i[1:0]);
         apb(1'b1, `SMR_OFF, {27'h0, i[2], 4'h0});
         repeat (10) @(posedge pclk);
         chk({fb_oe, mf_oe}, {2{~i[2]}}, "direction");
         apb(1'b0, `STATUS_OFF, 32'h0);
         chk(d[3:0], exp_status(i[1:0], i[2]), "status");
      end
      $display("test direction done");
      // System control with a random frame length and multiframe size
      rnd = lfsr(rnd);
      period <= 8'h28 + rnd[5:0];
      mf_len <= 4'h2 + rnd[9:8];
      go <= 1'b1;
      wait_frames(14);
      chk(fgap, period, "sys frame");
      chk(mgap, mf_len, "sys multiframe");
      chk({fb_oe, mf_oe}, 2'b00, "sys inputs");
      apb(1'b0, `STATUS_OFF, 32'h0);
      chk(d[4], 1'b1, "sys locked");
      $display("test system control done");
      // Not base rate: multiframe pin turns clock, its pulses ignored
      apb(1'b1, `CLKSEL_OFF, 32'h0);
      repeat (10) @(posedge pclk);
      chk(mclk, 1'b1, "pin is clock");
      m = nm;
      wait_frames(8);
      chk(nm, m, "mf ignored");
      chk(fgap, period, "frames kept");
      $display("test rate mode done");
      finish_test();
   end
endmodule
`default_nettype wire
